// ### rtl/sfb_uart.sv
// Purpose: character framing, divisor latches and serial shifters
// Assumes: i_serial_in and i_ref_tick are synchronous to i_clk
// Notes: register read data stand in the cycle after the read strobe
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "sfb_regs.svh"
module sfb_uart (
  input wire logic i_clk, // system clock, 25 MHz
  input wire logic i_srst, // synchronous reset, high
  input wire sfb_pkg::sfb_bus_req_s i_bus, // register access request
  output logic [7:0] o_rdata, // read data, cycle after read strobe
  input wire logic [3:0] i_ref_tick, // source clock pulses, one per source
  input wire logic i_serial_in, // serial receive line
  output logic o_serial_out, // serial transmit line
  output logic o_tick16 // 16x bit clock enable
);

  sfb_pkg::sfb_core_s s;
  sfb_pkg::sfb_core_s next_s;
  logic w_tick;
  logic w_div_wr;
  logic w_tx_end;
  logic w_rx_end;
  logic [2:0] w_last_bit;
  logic [5:0] w_stop_ticks;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] len_mask(input sfb_pkg::sfb_lcr_s l);
    len_mask = 8'hff >> (2'h3 - {l.word_len_hi, l.word_len_lo});
  endfunction

  function automatic logic par_bit(input sfb_pkg::sfb_lcr_s l, input logic [7:0] d);
    logic ones;
    ones = ^(d & len_mask(l));
    if (l.parity_stick) begin
      par_bit = ~l.parity_even_select;
    end else if (l.parity_even_select) begin
      par_bit = ones;
    end else begin
      par_bit = ~ones;
    end
  endfunction

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------
  sfb_baud_gen u_baud (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_src_tick(i_ref_tick[s.clk_sel]),
    .i_divisor({s.div_hi, s.div_lo}),
    .i_reload(s.div_reload),
    .o_tick16(w_tick)
  );

  // ---------------------------------------------------------------
  // shared decode
  // ---------------------------------------------------------------
  assign w_div_wr = i_bus.wr && s.lcr.divisor_access &&
                    (i_bus.addr == `SFB_OFS_DATA || i_bus.addr == `SFB_OFS_IER);
  assign w_tx_end = w_tick && (s.tx_tick == 6'h00);
  assign w_rx_end = w_tick && (s.rx_tick == 6'h00);
  assign w_last_bit = {1'b0, s.lcr.word_len_hi, s.lcr.word_len_lo} + 3'h4;

  always_comb begin
    if (!s.lcr.stop_bits_sel) begin
      w_stop_ticks = `SFB_BIT_TICKS;
    end else if ({s.lcr.word_len_hi, s.lcr.word_len_lo} == 2'h0) begin
      w_stop_ticks = `SFB_STOP15_TICKS;
    end else begin
      w_stop_ticks = `SFB_STOP2_TICKS;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    next_s.div_reload = w_div_wr;

    // register reads and their side effects
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `SFB_OFS_DATA: begin
          if (s.lcr.divisor_access) begin
            next_s.rdata = s.div_lo;
          end else begin
            next_s.rdata = s.rbr;
            next_s.dr = 1'b0;
          end
        end
        `SFB_OFS_IER: begin
          next_s.rdata = s.lcr.divisor_access ? s.div_hi : s.ier;
        end
        `SFB_OFS_LCR: begin
          next_s.rdata = s.lcr;
        end
        `SFB_OFS_LSR: begin
          next_s.rdata[`SFB_LSR_DR] = s.dr;
          next_s.rdata[`SFB_LSR_OE] = s.oe;
          next_s.rdata[`SFB_LSR_PE] = s.pe;
          next_s.rdata[`SFB_LSR_FE] = s.fe;
          next_s.rdata[`SFB_LSR_BI] = s.bi;
          next_s.rdata[`SFB_LSR_THRE] = ~s.thr_full;
          next_s.rdata[`SFB_LSR_TEMT] = ~s.thr_full && (s.tx_st == sfb_pkg::TX_IDLE);
          next_s.oe = 1'b0;
          next_s.pe = 1'b0;
          next_s.fe = 1'b0;
          next_s.bi = 1'b0;
        end
        `SFB_OFS_CLKSEL: begin
          next_s.rdata = {6'h00, s.clk_sel};
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end

    // receiver; its flags are set after the read clears so a set wins
    if (w_tick && s.rx_tick != 6'h00) begin
      next_s.rx_tick = s.rx_tick - 6'h01;
    end
    unique case (s.rx_st)
      sfb_pkg::RX_IDLE: begin
        if (w_tick && !i_serial_in) begin
          next_s.rx_st = sfb_pkg::RX_START;
          next_s.rx_tick = `SFB_HALF_TICKS - 6'h01;
        end
      end
      sfb_pkg::RX_START: begin
        if (w_rx_end) begin
          if (!i_serial_in) begin
            next_s.rx_st = sfb_pkg::RX_DATA;
            next_s.rx_tick = `SFB_BIT_TICKS - 6'h01;
            next_s.rx_bit = 3'h0;
            next_s.rx_sh = 8'h00;
            next_s.rx_par_lvl = 1'b0;
          end else begin
            next_s.rx_st = sfb_pkg::RX_IDLE;
          end
        end
      end
      sfb_pkg::RX_DATA: begin
        if (w_rx_end) begin
          next_s.rx_sh[s.rx_bit] = i_serial_in;
          next_s.rx_tick = `SFB_BIT_TICKS - 6'h01;
          if (s.rx_bit == w_last_bit) begin
            next_s.rx_st = s.lcr.parity_on ? sfb_pkg::RX_PARITY : sfb_pkg::RX_STOP;
          end else begin
            next_s.rx_bit = s.rx_bit + 3'h1;
          end
        end
      end
      sfb_pkg::RX_PARITY: begin
        if (w_rx_end) begin
          next_s.rx_par_lvl = i_serial_in;
          next_s.rx_tick = `SFB_BIT_TICKS - 6'h01;
          next_s.rx_st = sfb_pkg::RX_STOP;
        end
      end
      sfb_pkg::RX_STOP: begin
        if (w_rx_end) begin
          next_s.rbr = s.rx_sh;
          next_s.oe = next_s.oe | next_s.dr;
          next_s.dr = 1'b1;
          if (s.lcr.parity_on && s.rx_par_lvl != par_bit(s.lcr, s.rx_sh)) begin
            next_s.pe = 1'b1;
          end
          if (!i_serial_in) begin
            next_s.fe = 1'b1;
          end
          if (!i_serial_in && s.rx_sh == 8'h00 && !s.rx_par_lvl) begin
            next_s.bi = 1'b1;
          end
          next_s.rx_st = sfb_pkg::RX_IDLE;
        end
      end
      default: begin
        next_s.rx_st = sfb_pkg::RX_IDLE;
      end
    endcase

    // transmitter
    if (w_tick && s.tx_tick != 6'h00) begin
      next_s.tx_tick = s.tx_tick - 6'h01;
    end
    unique case (s.tx_st)
      sfb_pkg::TX_IDLE: begin
        if (s.thr_full) begin
          next_s.tx_sh = s.thr;
          next_s.thr_full = 1'b0;
          next_s.tx_par = par_bit(s.lcr, s.thr);
          next_s.tx_bit = 3'h0;
          next_s.tx_tick = `SFB_BIT_TICKS - 6'h01;
          next_s.tx_st = sfb_pkg::TX_START;
        end
      end
      sfb_pkg::TX_START: begin
        if (w_tx_end) begin
          next_s.tx_tick = `SFB_BIT_TICKS - 6'h01;
          next_s.tx_st = sfb_pkg::TX_DATA;
        end
      end
      sfb_pkg::TX_DATA: begin
        if (w_tx_end) begin
          next_s.tx_sh = s.tx_sh >> 1;
          if (s.tx_bit == w_last_bit) begin
            if (s.lcr.parity_on) begin
              next_s.tx_tick = `SFB_BIT_TICKS - 6'h01;
              next_s.tx_st = sfb_pkg::TX_PARITY;
            end else begin
              next_s.tx_tick = w_stop_ticks - 6'h01;
              next_s.tx_st = sfb_pkg::TX_STOP;
            end
          end else begin
            next_s.tx_bit = s.tx_bit + 3'h1;
            next_s.tx_tick = `SFB_BIT_TICKS - 6'h01;
          end
        end
      end
      sfb_pkg::TX_PARITY: begin
        if (w_tx_end) begin
          next_s.tx_tick = w_stop_ticks - 6'h01;
          next_s.tx_st = sfb_pkg::TX_STOP;
        end
      end
      sfb_pkg::TX_STOP: begin
        if (w_tx_end) begin
          next_s.tx_st = sfb_pkg::TX_IDLE;
        end
      end
      default: begin
        next_s.tx_st = sfb_pkg::TX_IDLE;
      end
    endcase

    // register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        `SFB_OFS_DATA: begin
          if (s.lcr.divisor_access) begin
            next_s.div_lo = i_bus.wdata;
          end else begin
            next_s.thr = i_bus.wdata;
            next_s.thr_full = 1'b1;
          end
        end
        `SFB_OFS_IER: begin
          if (s.lcr.divisor_access) begin
            next_s.div_hi = i_bus.wdata;
          end else begin
            next_s.ier = i_bus.wdata & `SFB_IER_MASK;
          end
        end
        `SFB_OFS_LCR: begin
          next_s.lcr = i_bus.wdata;
        end
        `SFB_OFS_CLKSEL: begin
          next_s.clk_sel = i_bus.wdata[1:0];
        end
        default: begin
          next_s.clk_sel = s.clk_sel;
        end
      endcase
    end

    // divisor write: receiver drops at once, waiting character is discarded,
    // the shifter keeps running until its character is out
    if (w_div_wr) begin
      next_s.rx_st = sfb_pkg::RX_IDLE;
      next_s.rx_tick = 6'h00;
      next_s.thr_full = 1'b0;
    end

    // serial line level, registered
    unique case (next_s.tx_st)
      sfb_pkg::TX_START: next_s.serial_out = 1'b0;
      sfb_pkg::TX_DATA: next_s.serial_out = next_s.tx_sh[0];
      sfb_pkg::TX_PARITY: next_s.serial_out = next_s.tx_par;
      default: next_s.serial_out = 1'b1;
    endcase
    if (next_s.lcr.break_force) begin
      next_s.serial_out = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s <= '0;
      s.lcr <= `SFB_RST_LCR;
      s.div_lo <= `SFB_RST_DIV;
      s.div_hi <= `SFB_RST_DIV;
      s.ier <= `SFB_RST_IER;
      s.clk_sel <= `SFB_RST_CLKSEL;
      s.tx_st <= sfb_pkg::TX_IDLE;
      s.rx_st <= sfb_pkg::RX_IDLE;
      s.serial_out <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rdata = s.rdata;
  assign o_serial_out = s.serial_out;
  assign o_tick16 = w_tick;

endmodule

// ### rtl/sfb_regs.svh
// Purpose: register offsets, field positions, reset values and tick counts
// Assumes: byte registers on a 3-bit address, one 8-bit data lane
// Notes: included by the framing block and the self-checking bench, not by the package
//
// Contract
// - parity on, even clear: odd ones total
// - parity on, even set: even ones total
// - parity off: no parity sent or checked
// - parity bit after data, before stop
// - stop select clear: one stop bit
// - stop select set, five bits: 1.5 stops
// - stop select set, 6-8 bits: two stops
// - word length field gives five to eight
// - generator output is input over divisor
// - divisor is two 8-bit latches, 16 bits
// - divisor write reloads baud counter at once
// - divisor write idles transmitter and receiver
// - transmitter finishes shifting character before idle
// - generator source clock is selectable
// - stick parity sends opposite of even select
// - divisor access maps low addresses to divisor
// - break holds serial output low
`ifndef SFB_REGS_SVH
`define SFB_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SFB_OFS_DATA 3'h0
`define SFB_OFS_IER 3'h1
`define SFB_OFS_LCR 3'h3
`define SFB_OFS_LSR 3'h5
`define SFB_OFS_CLKSEL 3'h7

// ---------------------------------------------------------------
// field positions and masks
// ---------------------------------------------------------------
`define SFB_LSR_DR 0
`define SFB_LSR_OE 1
`define SFB_LSR_PE 2
`define SFB_LSR_FE 3
`define SFB_LSR_BI 4
`define SFB_LSR_THRE 5
`define SFB_LSR_TEMT 6
`define SFB_IER_MASK 8'h0f

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SFB_RST_LCR 8'h00
`define SFB_RST_DIV 8'h00
`define SFB_RST_IER 8'h00
`define SFB_RST_CLKSEL 2'h0

// ---------------------------------------------------------------
// tick counts on the 16x clock
// ---------------------------------------------------------------
`define SFB_BIT_TICKS 6'h10
`define SFB_HALF_TICKS 6'h08
`define SFB_STOP15_TICKS 6'h18
`define SFB_STOP2_TICKS 6'h20

`endif

// ### rtl/sfb_pkg.sv
// Purpose: shared types of the serial framing block
// Assumes: nothing beyond the register header
// Notes: types only; constants live in sfb_regs.svh
package sfb_pkg;

  typedef struct packed {
    logic divisor_access;
    logic break_force;
    logic parity_stick;
    logic parity_even_select;
    logic parity_on;
    logic stop_bits_sel;
    logic word_len_hi;
    logic word_len_lo;
  } sfb_lcr_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } sfb_bus_req_s;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} sfb_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} sfb_rx_e;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } sfb_baud_s;

  typedef struct packed {
    sfb_lcr_s lcr;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic div_reload;
    logic [7:0] ier;
    logic [1:0] clk_sel;
    logic [7:0] thr;
    logic thr_full;
    sfb_tx_e tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic [5:0] tx_tick;
    logic tx_par;
    logic serial_out;
    sfb_rx_e rx_st;
    logic [7:0] rx_sh;
    logic [2:0] rx_bit;
    logic [5:0] rx_tick;
    logic rx_par_lvl;
    logic [7:0] rbr;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [7:0] rdata;
  } sfb_core_s;

endpackage

// ### rtl/sfb_baud_gen.sv
// Purpose: programmable divider making the 16x bit clock enable
// Assumes: source ticks are one-cycle pulses at the selected input rate
// Notes: a divisor of zero behaves as a divisor of one
`timescale 1ns/1ps
module sfb_baud_gen (
  input wire logic i_clk, // system clock
  input wire logic i_srst, // synchronous reset, high
  input wire logic i_src_tick, // selected source clock pulse
  input wire logic [15:0] i_divisor, // programmed divisor
  input wire logic i_reload, // divisor latch was written
  output logic o_tick16 // one pulse per 16x period
);

  sfb_pkg::sfb_baud_s s;
  sfb_pkg::sfb_baud_s next_s;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (i_reload) begin
      next_s.cnt = i_divisor;
    end else if (i_src_tick) begin
      if (s.cnt <= 16'h0001) begin
        next_s.cnt = i_divisor;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick16 = s.tick;

endmodule

// ### test/sfb_uart_sva.sv
// Purpose: concurrent checks on the serial framing block ports
// Assumes: one clock domain, synchronous active-high reset
// Notes: shadows line control, divisor and source select from bus writes
`timescale 1ns/1ps
module sfb_uart_sva (
  input wire logic i_clk, // system clock
  input wire logic i_srst, // synchronous reset, high
  input wire sfb_pkg::sfb_bus_req_s i_bus, // register request
  input wire logic [7:0] o_rdata, // read data
  input wire logic [3:0] i_ref_tick, // source pulses
  input wire logic i_serial_in, // receive line
  input wire logic o_serial_out, // transmit line
  input wire logic o_tick16 // 16x enable
);
  logic [7:0] lcr, dl, dh;
  logic [1:0] sel;
  int lowcnt, pcnt, dv;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  assign dv = ({dh, dl} == 16'h0000) ? 1 : int'({dh, dl});
  // ---------------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lcr <= 8'h00;
      dl <= 8'h00;
      dh <= 8'h00;
      sel <= 2'h0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == 3'h3) lcr <= i_bus.wdata;
      if (i_bus.addr == 3'h7) sel <= i_bus.wdata[1:0];
      if (i_bus.addr == 3'h0 && lcr[7]) dl <= i_bus.wdata;
      if (i_bus.addr == 3'h1 && lcr[7]) dh <= i_bus.wdata;
    end
  end
  // low-run length of the line and source pulses since the last 16x tick
  always_ff @(posedge i_clk) begin
    if (i_srst || o_serial_out) lowcnt <= 0;
    else if (lcr[6]) lowcnt <= 64;
    else lowcnt <= lowcnt + 1;
    if (i_srst || o_tick16 || (i_bus.wr && lcr[7] && i_bus.addr[2:1] == 2'b00)) pcnt <= 0;
    else if (i_ref_tick[sel]) pcnt <= pcnt + 1;
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_RESET_IDLE: assert property ($past(i_srst) |-> o_serial_out && !o_tick16)
    else $error("outputs not idle after reset");
  AST_RDATA_QUIET: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data without a read");
  AST_LCR_BACK: assert property ($past(i_bus.rd && i_bus.addr == 3'h3) |-> o_rdata == lcr)
    else $error("line control readback wrong");
  AST_DLO_BACK: assert property ($past(i_bus.rd && i_bus.addr == 3'h0 && lcr[7]) |-> o_rdata == dl)
    else $error("divisor low readback wrong");
  AST_DHI_BACK: assert property ($past(i_bus.rd && i_bus.addr == 3'h1 && lcr[7]) |-> o_rdata == dh)
    else $error("divisor high readback wrong");
  AST_UNMAPPED: assert property ($past(i_bus.rd && !i_bus.addr[0] && i_bus.addr != 3'h0)
    |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_BREAK: assert property (lcr[6] && $past(lcr[6]) |-> !o_serial_out)
    else $error("line not held low in break");
  AST_START_MIN: assert property ($rose(o_serial_out) |-> lowcnt >= 16)
    else $error("low period shorter than one bit");
  AST_TICK_BOUND: assert property (pcnt <= dv + 1)
    else $error("16x tick late for divisor");
endmodule
bind sfb_uart sfb_uart_sva sva_u (.i_clk(i_clk), .i_srst(i_srst), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_ref_tick(i_ref_tick), .i_serial_in(i_serial_in),
  .o_serial_out(o_serial_out), .o_tick16(o_tick16));

// ### test/sfb_remote.sv
// Purpose: far-end serial terminal driving the receive line
// Assumes: each frame is started just after a rising clock edge
// Notes: the line rests high between frames
`timescale 1ns/1ps
module sfb_remote #(parameter int BIT_CYC = 64) (
  input wire logic i_clk, // system clock
  output logic o_line // serial line into the block
);
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] d, input int n, input logic pon, input logic pb);
    logic b[$];
    b = {1'b0};
    for (int k = 0; k < n; k++) b.push_back(d[k]);
    if (pon) b.push_back(pb);
    b.push_back(1'b1);
    foreach (b[k]) begin
      o_line <= b[k];
      repeat (BIT_CYC) @(posedge i_clk);
    end
  endtask
endmodule

// ### test/tb_sfb_uart.sv
// Purpose: self-checking bench for the serial framing block
// Assumes: source 2 pulses every 4 cycles, so divisor 1 gives 64 cycles a bit
// Notes: line and tick levels are logged each cycle and decoded afterwards
`timescale 1ns/1ps
`include "sfb_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_sfb_uart;
  logic i_clk, i_srst, o_serial_out, o_tick16, i_serial_in;
  logic [7:0] o_rdata, v, d;
  logic [3:0] i_ref_tick;
  sfb_pkg::sfb_bus_req_s i_bus;
  logic hist [0:131071];
  logic tk [0:131071];
  int fail_count, samples_checked, a, f, g;
  int cyc = 0;
  logic [7:0] lt [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0b, 8'h1b, 8'h2b, 8'h3b, 8'h04,
    8'h07, 8'h0e};
  int rt [4] = '{5, 3, 4, 6};
  sfb_uart dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_ref_tick(i_ref_tick), .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
    .o_tick16(o_tick16));
  sfb_remote far_u (.i_clk(i_clk), .o_line(i_serial_in));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    hist[cyc] <= o_serial_out;
    tk[cyc] <= o_tick16;
    i_ref_tick <= {cyc % 6 == 0, cyc % 4 == 0, cyc % 3 == 0, cyc % 5 == 0};
  end
  // ---------------------------------------------------------------
  // bus tasks and model
  // ---------------------------------------------------------------
  task automatic wr(input logic [2:0] ad, input logic [7:0] x);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: x};
    @(posedge i_clk);
    i_bus <= '0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [2:0] ad, output logic [7:0] x);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge i_clk);
    i_bus <= '0;
    #1 x = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic setdiv(input logic [15:0] x);
    wr(3'h3, 8'h83);
    wr(3'h0, x[7:0]);
    wr(3'h1, x[15:8]);
    wr(3'h3, 8'h03);
  endtask
  function automatic logic pbit(input logic [7:0] l, input logic [7:0] x);
    logic [7:0] m;
    m = x & (8'hff >> (3 - l[1:0]));
    return l[5] ? ~l[4] : (l[4] ? ^m : ~^m);
  endfunction
  task automatic txrx(input logic [7:0] l);
    logic b[$];
    logic bad;
    int s, st, n;
    d = $urandom;
    bad = 1'($urandom_range(0, 1));
    n = 5 + l[1:0];
    st = l[2] ? (n == 5 ? 24 : 32) : 16;
    b = {1'b0};
    for (int k = 0; k < n; k++) b.push_back(d[k]);
    if (l[3]) b.push_back(pbit(l, d));
    b.push_back(1'b1);
    wr(3'h3, l);
    s = cyc;
    wr(3'h0, d);
    repeat (4) @(posedge i_clk);
    wr(3'h0, ~d);
    repeat (b.size() * 128 + 400) @(posedge i_clk);
    f = s;
    while (hist[f] !== 1'b0 && f < cyc) f++;
    foreach (b[k]) `CHK(hist[f + 32 + 64 * k], b[k])
    g = f + (b.size() - 1) * 64 + st * 4 - 8;
    while (hist[g] !== 1'b0 && g < cyc) g++;
    `CHK((g - f - (b.size() - 1) * 64 - st * 4) inside {[-2:2]}, 1'b1)
    far_u.send(d, n, l[3], pbit(l, d) ^ bad);
    repeat (200) @(posedge i_clk);
    rd(3'h5, v);
    `CHK(v[6:0], {4'hc, l[3] & bad, 2'b01})
    rd(3'h0, v);
    `CHK(v, d & (8'hff >> (3 - l[1:0])))
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    i_srst = 1'b1;
    i_bus = '0;
    void'($urandom(86024));
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rd(3'h3, v);
    `CHK(v, 8'h00)
    wr(3'h3, 8'h80);
    rd(3'h0, v);
    `CHK(v, 8'h00)
    d = $urandom;
    wr(3'h0, d);
    wr(3'h1, ~d);
    rd(3'h0, v);
    `CHK(v, d)
    rd(3'h1, v);
    `CHK(v, ~d)
    wr(3'h3, 8'h03);
    wr(3'h1, 8'hff);
    rd(3'h1, v);
    `CHK(v, `SFB_IER_MASK)
    for (a = 2; a < 7; a += 2) begin
      wr(a[2:0], 8'h5a);
      rd(a[2:0], v);
      `CHK(v, 8'h00)
    end
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      for (int k = 1; k < 4; k++) begin
        wr(3'h7, s[7:0]);
        setdiv(k[15:0]);
        repeat (80) @(posedge i_clk);
        a = cyc - 40;
        while (tk[a] !== 1'b1 && a < cyc) a++;
        g = a + 1;
        while (tk[g] !== 1'b1 && g < cyc) g++;
        `CHK(g - a, k * rt[s])
      end
    end
    wr(3'h7, 8'h02);
    setdiv(16'h0001);
    $display("test baud done");
    foreach (lt[i]) txrx(lt[i]);
    $display("test frames done");
    wr(3'h3, 8'h03);
    d = $urandom;
    a = cyc;
    wr(3'h0, d);
    repeat (4) @(posedge i_clk);
    wr(3'h0, ~d);
    repeat (20) @(posedge i_clk);
    setdiv(16'h0001);
    repeat (2000) @(posedge i_clk);
    f = a;
    while (hist[f] !== 1'b0 && f < cyc) f++;
    `CHK(hist[f + 32 + 64 * 8], d[7])
    `CHK(hist[f + 32 + 64 * 9], 1'b1)
    g = f + 64 * 10;
    while (hist[g] !== 1'b0 && g < cyc) g++;
    `CHK(g, cyc)
    $display("test divisor write done");
    wr(3'h3, 8'h43);
    repeat (100) @(posedge i_clk);
    `CHK(hist[cyc - 1], 1'b0)
    wr(3'h3, 8'h03);
    repeat (4) @(posedge i_clk);
    `CHK(hist[cyc - 1], 1'b1)
    $display("test break done");
    stop_test();
  end
endmodule
